// ---- logic/mes_pkg.sv ----
// constants, types and crc helper for the encoder spi readout
package mes_pkg;
   localparam int ANG_W    = 17;               // angle resolution r
   localparam int TURN_W   = 12;
   localparam int FRAME_W  = 64;
   localparam int CLK_NS   = 40;
   localparam int TM_NS    = 90000;            // measurement time, least
   localparam int TMTO_NS  = 135000;           // measurement timeout, least
   localparam int TCKI_NS  = 10000;            // clock idle frame reset
   localparam int TM_CYC   = (TM_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMTO_CYC = (TMTO_NS + CLK_NS - 1) / CLK_NS;
   localparam int TCKI_CYC = (TCKI_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W    = 12;
   localparam int BIT_W    = 6;
   // frame field positions
   localparam int ZPD_BIT  = 48;
   localparam int POS_BIT  = 47;
   localparam int TRN_BIT  = 46;
   localparam int SYN_BIT  = 45;
   localparam int ZHI_BIT  = 44;
   localparam int ZTOP_LO  = 49;
   localparam int ANG_LSB  = 8;
   localparam int TURN_LSB = ANG_W + 8;
   localparam int STL_BIT  = 7;
   localparam int CRC_W    = 7;
   localparam int CRC_HI   = 32;
   localparam int CRC_PAD  = 6;
   localparam logic [CRC_W-1:0] CRC_POLY = 7'h5B;
   // register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STAT  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_ANGLE = 8'h08;
   localparam logic [ADDR_W-1:0] REG_TURN  = 8'h0C;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              zero_point_default_flag;
      logic              pos_ok;
      logic              turn_ok;
      logic [TURN_W-1:0] turn;
      logic [ANG_W-1:0]  angle;
   } mes_sens_t;

   typedef struct packed {
      mes_sens_t s;
      logic      ps;
   } mes_meas_t;

   typedef enum logic [1:0] {MS_IDLE = 2'b01, MS_BUSY = 2'b10} mes_ms_t;
   typedef enum logic [2:0] {FR_IDLE = 3'b001, FR_SHIFT = 3'b010, FR_DONE = 3'b100} mes_fr_t;

   // crc7, msb first, zero start, no final xor
   function automatic logic [CRC_W-1:0] mes_crc7(input logic [31:0] d);
      logic [CRC_W-1:0] c;
      logic             fb;
      c = '0;
      for (int i = 31; i >= 0; i--) begin
         fb = c[CRC_W-1] ^ d[i];
         c  = {c[CRC_W-2:0], 1'b0};
         if (fb) begin
            c = c ^ CRC_POLY;
         end
      end
      return c;
   endfunction
endpackage

// ---- logic/mes_top.sv ----
// spi readout with measurement timing and axi4-lite registers
`timescale 1ns/10ps
// How it works
// - frame is 64 bits, eight bytes
// - unused upper frame bits send zero
// - bit 48 flags default zero point
// - bit 47 high when angle valid
// - bit 46 high when turns valid
// - bit 45 high for frame-started measurement
// - twelve-bit turn count above angle field
// - angle field sits from bit 8
// - bit 7 marks already sent result
// - bits 6..0 carry crc7 poly 5B
// - crc covers bits 7..32 zero padded
// - measurement completes 90..95 us after start
// - timeout starts measurement after 135..145 us
// - frame start triggers measurement when idle
// - running measurement is never restarted
// - frames carry last completed result only
// - long clock idle resets frame logic
// - clock idles high, launch on rise
module mes_top
   import mes_pkg::*;
(
   // clock, reset, enable
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    ce,
   // axi4-lite write
   input  wire logic [mes_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   // axi4-lite read
   input  wire logic [mes_pkg::ADDR_W-1:0] araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   // spi link
   input  wire logic                    sclk,
   output logic                         miso,
   // sensor front end
   input  wire mes_pkg::mes_sens_t      sens,
   output logic                         meas_start
);
   import mes_pkg::*;

   logic             sclk_s1, sclk_s2, sclk_s3;
   logic             rise, fall, sedge;
   mes_fr_t          fr, next_fr;
   logic [BIT_W-1:0] bits, next_bits;
   logic [FRAME_W-1:0] shreg, next_shreg, frame_word;
   logic [CNT_W-1:0] idle_cnt, next_idle_cnt;
   logic             next_miso, frame_start, idle_out;
   mes_ms_t          ms, next_ms;
   logic [CNT_W-1:0] mcnt, next_mcnt, tcnt, next_tcnt;
   mes_meas_t        res, next_res;
   logic             sent, next_sent, ps_src, next_ps_src, next_meas_start;
   logic             trig_frame, trig_to, done_now;
   logic             link_en, next_link_en;
   logic             aw_held, next_aw_held, w_held, next_w_held;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0]      w_data, next_w_data;
   logic             next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]       next_bresp, next_rresp;
   logic [31:0]      next_rdata;

   // sclk synchroniser and edge detect, idle high mode 3-less-phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_s3 <= 1'b1;
      end else if (ce) begin
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
      end
   end
   assign rise  = ce & sclk_s2 & ~sclk_s3;
   assign fall  = ce & ~sclk_s2 & sclk_s3;
   assign sedge = rise | fall;

   // frame word from latest completed result
   always_comb begin
      frame_word = '0;
      frame_word[ZPD_BIT] = res.s.zero_point_default_flag;
      frame_word[POS_BIT] = res.s.pos_ok;
      frame_word[TRN_BIT] = res.s.turn_ok;
      frame_word[SYN_BIT] = res.ps;
      frame_word[TURN_LSB +: TURN_W] = res.s.turn;
      frame_word[ANG_LSB +: ANG_W] = res.s.angle;
      frame_word[STL_BIT] = sent;
      frame_word[CRC_W-1:0] = mes_crc7({{CRC_PAD{1'b0}}, frame_word[CRC_HI:STL_BIT]});
   end

   // frame sequencer: start on fall, shift on rise, reset on idle
   assign idle_out = (idle_cnt == CNT_W'(TCKI_CYC)) & ~sedge;
   always_comb begin
      next_fr       = fr;
      next_bits     = bits;
      next_shreg    = shreg;
      frame_start   = 1'b0;
      next_idle_cnt = idle_cnt;
      if (sedge) begin
         next_idle_cnt = '0;
      end else if (ce && idle_cnt != CNT_W'(TCKI_CYC)) begin
         next_idle_cnt = idle_cnt + 1'b1;
      end
      unique case (fr)
         FR_IDLE: begin
            if (fall && link_en) begin
               frame_start = 1'b1;
               next_shreg  = frame_word;
               next_bits   = '0;
               next_fr     = FR_SHIFT;
            end
         end
         FR_SHIFT: begin
            if (rise) begin
               next_shreg = {shreg[FRAME_W-2:0], 1'b0};
               if (bits == BIT_W'(FRAME_W - 1)) begin
                  next_fr = FR_DONE;
               end else begin
                  next_bits = bits + 1'b1;
               end
            end
         end
         FR_DONE: begin
         end
      endcase
      if (ce && idle_out) begin
         next_fr    = FR_IDLE;
         next_bits  = '0;
         next_shreg = '0;
      end
      next_miso = next_shreg[FRAME_W-1];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fr       <= FR_IDLE;
         bits     <= '0;
         shreg    <= '0;
         idle_cnt <= '0;
         miso     <= 1'b0;
      end else if (ce) begin
         fr       <= next_fr;
         bits     <= next_bits;
         shreg    <= next_shreg;
         idle_cnt <= next_idle_cnt;
         miso     <= next_miso;
      end
   end

   // measurement timing and result latch
   assign trig_frame = frame_start & (ms == MS_IDLE);
   assign trig_to    = ce & (ms == MS_IDLE) & (tcnt == CNT_W'(TMTO_CYC - 1)) & ~trig_frame;
   assign done_now   = ce & (ms == MS_BUSY) & (mcnt == CNT_W'(TM_CYC - 1));
   always_comb begin
      next_ms         = ms;
      next_mcnt       = mcnt;
      next_tcnt       = (tcnt == CNT_W'(TMTO_CYC - 1)) ? tcnt : tcnt + 1'b1;
      next_res        = res;
      next_sent       = sent;
      next_ps_src     = ps_src;
      next_meas_start = trig_frame | trig_to;
      if (frame_start) begin
         next_sent = 1'b1;
      end
      unique case (ms)
         MS_IDLE: begin
            if (trig_frame || trig_to) begin
               next_ms     = MS_BUSY;
               next_mcnt   = '0;
               next_tcnt   = '0;
               next_ps_src = trig_frame;
            end
         end
         MS_BUSY: begin
            next_mcnt = mcnt + 1'b1;
            if (done_now) begin
               next_ms   = MS_IDLE;
               next_res  = '{s: sens, ps: ps_src};
               next_sent = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms         <= MS_IDLE;
         mcnt       <= '0;
         tcnt       <= '0;
         res        <= '0;
         sent       <= 1'b0;
         ps_src     <= 1'b0;
         meas_start <= 1'b0;
      end else if (ce) begin
         ms         <= next_ms;
         mcnt       <= next_mcnt;
         tcnt       <= next_tcnt;
         res        <= next_res;
         sent       <= next_sent;
         ps_src     <= next_ps_src;
         meas_start <= next_meas_start;
      end
   end

   // axi4-lite slave: address and data in either order
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_link_en = link_en;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_data = wdata;
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_held && w_held && !bvalid) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OKAY;
         if (aw_addr == REG_CTRL) begin
            if (wstrb[0]) begin
               next_link_en = w_data[0];
            end
         end else if (aw_addr != REG_STAT && aw_addr != REG_ANGLE && aw_addr != REG_TURN) begin
            next_bresp = RESP_SLVERR;
         end
      end
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         unique case (araddr)
            REG_CTRL:  next_rdata = {31'h0, link_en};
            REG_STAT:  next_rdata = {28'h0, sent, res.ps, fr != FR_IDLE, ms == MS_BUSY};
            REG_ANGLE: next_rdata = {{(32 - ANG_W){1'b0}}, res.s.angle};
            REG_TURN:  next_rdata = {13'h0, res.s.zero_point_default_flag, res.s.pos_ok, res.s.turn_ok,
                                     4'h0, res.s.turn};
            default: begin
               next_rdata = '0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
      next_awready = ~next_aw_held & ~next_bvalid;
      next_wready  = ~next_w_held & ~next_bvalid;
      next_arready = ~next_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held  <= 1'b0;
         w_data  <= '0;
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         link_en <= 1'b1;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (ce) begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held  <= next_w_held;
         w_data  <= next_w_data;
         awready <= next_awready;
         wready  <= next_wready;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         link_en <= next_link_en;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // checks on frame content, shifting and timing
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_zero_fill;
      frame_start |=> shreg[FRAME_W-1:ZTOP_LO] == '0 && shreg[ZHI_BIT:TURN_LSB+TURN_W] == '0;
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("zero fill bits set");
   property p_flags;
      frame_start |=> shreg[ZPD_BIT] == $past(res.s.zero_point_default_flag) && shreg[POS_BIT] == $past(res.s.pos_ok);
   endproperty
   a_flags: assert property (p_flags) else $error("flag bits wrong");
   property p_sync;
      frame_start |=> shreg[SYN_BIT] == $past(res.ps) && shreg[TRN_BIT] == $past(res.s.turn_ok);
   endproperty
   a_sync: assert property (p_sync) else $error("sync bit wrong");
   property p_stale;
      frame_start && !done_now |=> sent;
   endproperty
   a_stale: assert property (p_stale) else $error("stale flag not set");
   property p_crc;
      frame_start |=> shreg[CRC_W-1:0] == mes_crc7({{CRC_PAD{1'b0}}, shreg[CRC_HI:STL_BIT]});
   endproperty
   a_crc: assert property (p_crc) else $error("crc mismatch");
   property p_shift;
      rise && fr == FR_SHIFT && !idle_out |=> shreg == {$past(shreg[FRAME_W-2:0]), 1'b0};
   endproperty
   a_shift: assert property (p_shift) else $error("shift not msb first");
   property p_idle_reset;
      ce && idle_out |=> fr == FR_IDLE && bits == '0;
   endproperty
   a_idle_reset: assert property (p_idle_reset) else $error("idle reset missed");
   property p_meas_len;
      ms == MS_BUSY ##1 ms == MS_IDLE |-> $past(mcnt) == CNT_W'(TM_CYC - 1);
   endproperty
   a_meas_len: assert property (p_meas_len) else $error("measurement length wrong");
   property p_timeout;
      ce && ms == MS_IDLE && tcnt == CNT_W'(TMTO_CYC - 1) |=> ms == MS_BUSY && meas_start;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout trigger missed");
   property p_no_restart;
      ce && ms == MS_BUSY && !done_now && frame_start |=> mcnt == $past(mcnt) + 1'b1;
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("measurement restarted");
endmodule

// ---- tb/mes_host.sv ----
// host spi master model that reads one encoder frame
`timescale 1ns/10ps
module mes_host (
   // spi link
   output logic      sclk,
   input  wire logic miso
);
   // clock idles high between frames
   initial sclk = 1'b1;

   // n bits at 320 ns, sampled on falls, byte gaps of 1 us
   task automatic xfer(input int n, output logic [63:0] f);
      f = '0;
      #7;
      for (int i = 0; i < n; i++) begin
         #160 sclk = 1'b0;
         f = {f[62:0], miso};
         #160 sclk = 1'b1;
         if (i % 8 == 7) begin
            #1000;
         end
      end
      #12000;
   endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the encoder spi readout
`timescale 1ns/10ps
module testbench;
   import mes_pkg::*;
   localparam int LIMIT = 50000;
   logic              aclk    = 1'b0;
   logic              aresetn = 1'b0;
   logic              ce      = 1'b1;
   logic [ADDR_W-1:0] awaddr  = '0;
   logic [ADDR_W-1:0] araddr  = '0;
   logic [31:0]       wdata   = '0;
   logic [3:0]        wstrb   = 4'hF;
   logic              awvalid = 1'b0;
   logic              wvalid  = 1'b0;
   logic              bready  = 1'b0;
   logic              arvalid = 1'b0;
   logic              rready  = 1'b0;
   logic [31:0]       rdata;
   logic [1:0]        bresp;
   logic [1:0]        rresp;
   logic              awready, wready, bvalid, arready, rvalid;
   logic              sclk, miso, meas_start;
   mes_sens_t         sens    = '0;
   int                err_total = 0;
   int                tests_run = 0;
   int                cyc       = 0;
   int                ms_n      = 0;
   // sensor rows, each giving its own expected frame
   mes_sens_t rows [3] = '{{1'b1, 1'b1, 1'b1, 12'hFFF, 17'h1FFFF},
                           {1'b0, 1'b1, 1'b1, 12'h001, 17'h00001},
                           {1'b1, 1'b0, 1'b0, 12'h5A5, 17'h0A5A5}};

   mes_top i_mes_top (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .sclk, .miso, .sens, .meas_start);
   mes_host i_mes_host (.sclk, .miso);

   // bench clock
   always #20 aclk = ~aclk;

   // cycle ceiling against hangs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_total++;
         conclude();
      end
   end

   // counts measurement triggers
   always @(negedge aclk) begin
      if (meas_start === 1'b1) begin
         ms_n <= ms_n + 1;
      end
   end

   task automatic conclude();
      if (err_total == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         err_total++;
      end
   endtask

   // expected frame with its own crc over bits 32..7
   function automatic logic [63:0] efr(mes_sens_t s, logic ps, logic sd);
      logic [63:0] f;
      logic [6:0]  c;
      logic        fb;
      f = {15'h0, s.zero_point_default_flag, s.pos_ok, s.turn_ok, ps, 8'h0, s.turn, s.angle, sd, 7'h0};
      c = 7'h0;
      for (int i = 32; i >= 7; i--) begin
         fb = c[6] ^ f[i];
         c  = {c[5:0], 1'b0};
         if (fb) begin
            c = c ^ 7'h5B;
         end
      end
      f[6:0] = c;
      return f;
   endfunction

   // axi4-lite write, both channels offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge aclk);
         ta = ta | awready;
         tw = tw | wready;
         @(posedge aclk);
         awvalid <= !ta;
         wvalid  <= !tw;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   // axi4-lite read
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   // one full frame, masked compare, optional trigger count
   task automatic frame(input logic [63:0] e, input logic [63:0] m, input int nt);
      logic [63:0] f;
      int          n0;
      n0 = ms_n;
      i_mes_host.xfer(64, f);
      chk("frame", f & m, e & m);
      if (nt >= 0) begin
         chk("triggers", 64'(ms_n - n0), 64'(nt));
      end
   endtask

   // main sequence
   initial begin
      logic [63:0] f;
      logic [63:0] m;
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (500) @(posedge aclk);
      chk("miso idle", 64'(miso), 64'h0);
      rd(REG_CTRL, d, r);
      chk("ctrl reset", 64'(d), 64'h1);
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk);
         sens <= rows[i];
         m = (rows[i].pos_ok & rows[i].turn_ok) ? '1 : {27'h7FFFFFF, 37'h0};
         frame('0, '0, 1);
         repeat (1500) @(posedge aclk);
         frame(efr(rows[i], 1'b1, 1'b0), m, 1);
         frame(efr(rows[i], 1'b1, 1'b1), m, 0);
         repeat (500) @(posedge aclk);
      end
      // timeout driven measurements, then an abandoned frame
      sens <= rows[0];
      n = ms_n;
      repeat (4700) @(posedge aclk);
      chk("timeouts", 64'(ms_n - n), 64'h2);
      frame(efr(rows[0], 1'b0, 1'b0), '1, 0);
      i_mes_host.xfer(20, f);
      frame(efr(rows[0], 1'b0, 1'b1), '1, -1);
      // link disabled, registers, unmapped place
      wr(REG_CTRL, 32'h0, r);
      chk("ctrl wr", 64'(r), 64'(RESP_OKAY));
      frame('0, '1, -1);
      wr(REG_CTRL, 32'h1, r);
      rd(REG_CTRL, d, r);
      chk("ctrl back", 64'(d), 64'h1);
      wr(8'h10, 32'h1, r);
      chk("bad wr", 64'(r), 64'(RESP_SLVERR));
      rd(8'h10, d, r);
      chk("bad rd data", 64'(d), 64'h0);
      chk("bad rd resp", 64'(r), 64'(RESP_SLVERR));
      rd(REG_TURN, d, r);
      chk("turn reg", 64'(d & 32'h00070FFF), 64'({3'h7, 4'h0, 12'hFFF}));
      // frozen clock enable holds off the timeout trigger
      @(posedge aclk);
      ce <= 1'b0;
      n = ms_n;
      repeat (4000) @(posedge aclk);
      chk("frozen", 64'(ms_n - n), 64'h0);
      ce <= 1'b1;
      // mid-run reset brings back the link enable
      wr(REG_CTRL, 32'h0, r);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("rst miso", 64'(miso), 64'h0);
      rd(REG_CTRL, d, r);
      chk("rst ctrl", 64'(d), 64'h1);
      conclude();
   end
endmodule
